// ---- verilog/bsu_pkg.sv ----
// Purpose: shared constants for the branch, skip and bit execution unit
// Assumes: 16-bit instruction words, 8-bit data, status register layout I T H S V N Z C
// Notes: opcode patterns are matched as (instr & mask) == pattern, except PAT_GIE, which is compared with the whole word
package bsu_pkg;

  // ----------------------------------------------------------------
  // status register bit positions
  // ----------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ----------------------------------------------------------------
  // opcode masks and patterns
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_CMPI = 16'hf000;
  localparam logic [15:0] PAT_CMPI = 16'h3000;
  localparam logic [15:0] MASK_SKIP_REG = 16'hfc08;
  localparam logic [15:0] PAT_SKIP_REG = 16'hfc00;
  localparam logic [15:0] MASK_SKIP_IO = 16'hfd00;
  localparam logic [15:0] PAT_SKIP_IO = 16'h9900;
  localparam logic [15:0] MASK_BRANCH = 16'hf800;
  localparam logic [15:0] PAT_BRANCH = 16'hf000;
  localparam logic [15:0] MASK_IO_BIT = 16'hfd00;
  localparam logic [15:0] PAT_IO_BIT = 16'h9800;
  localparam logic [15:0] MASK_ADD = 16'hfc00;
  localparam logic [15:0] PAT_SHL = 16'h0c00;
  localparam logic [15:0] PAT_ROTL = 16'h1c00;
  localparam logic [15:0] MASK_ONE = 16'hfe0f;
  localparam logic [15:0] PAT_SHR = 16'h9406;
  localparam logic [15:0] PAT_ROTR = 16'h9407;
  localparam logic [15:0] PAT_SHRA = 16'h9405;
  localparam logic [15:0] PAT_SWAP = 16'h9402;
  localparam logic [15:0] MASK_BITT = 16'hfe08;
  localparam logic [15:0] PAT_TSAVE = 16'hfa00;
  localparam logic [15:0] PAT_TLOAD = 16'hf800;
  localparam logic [15:0] PAT_GIE = 16'h9478;
  localparam logic [4:0] CMPI_REG_BASE = 5'h10;

  // ----------------------------------------------------------------
  // software port offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_PC_LO = 4'h1;
  localparam logic [3:0] OFS_PC_HI = 4'h2;
  localparam logic [3:0] OFS_CTRL = 4'h3;
  localparam logic [3:0] OFS_COUNT = 4'h4;
  localparam int CTRL_ENABLE = 0;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h01;

  // ----------------------------------------------------------------
  // timing counts (extra cycles beyond the first)
  // ----------------------------------------------------------------
  localparam logic [1:0] EXTRA_BRANCH = 2'h1;
  localparam logic [1:0] EXTRA_SKIP1 = 2'h1;
  localparam logic [1:0] EXTRA_SKIP2 = 2'h2;
  localparam logic [1:0] EXTRA_IO_BIT = 2'h1;

  typedef enum logic [3:0] {
    BSU_OP_NONE = 4'b0000,
    BSU_OP_CMPI = 4'b0001,
    BSU_OP_SKIP_REG = 4'b0010,
    BSU_OP_SKIP_IO = 4'b0011,
    BSU_OP_BRANCH = 4'b0100,
    BSU_OP_IO_BIT = 4'b0101,
    BSU_OP_SHL = 4'b0110,
    BSU_OP_SHR = 4'b0111,
    BSU_OP_ROTL = 4'b1000,
    BSU_OP_ROTR = 4'b1001,
    BSU_OP_SHRA = 4'b1010,
    BSU_OP_SWAP = 4'b1011,
    BSU_OP_TSAVE = 4'b1100,
    BSU_OP_TLOAD = 4'b1101,
    BSU_OP_GIE = 4'b1110
  } bsu_op_t;

  typedef enum logic [1:0] {
    BSU_ST_IDLE = 2'b00,
    BSU_ST_WAIT = 2'b01,
    BSU_ST_OFF = 2'b10
  } bsu_state_t;

endpackage

// ---- verilog/bsu_decode.sv ----
// Purpose: classify an instruction word and extract its fields
// Assumes: purely combinational, same clock domain as the caller
// Notes: shift forms built on add are only recognised when both operands match
module bsu_decode (
  // instruction
  input wire logic [15:0] instr,
  // decoded fields
  output bsu_pkg::bsu_op_t op,
  output logic [4:0] reg_addr,
  output logic [4:0] io_addr,
  output logic [2:0] bit_sel,
  output logic [7:0] imm,
  output logic [6:0] koff,
  output logic want_set
);
  import bsu_pkg::*;

  function automatic logic hit(input logic [15:0] w, input logic [15:0] m,
                               input logic [15:0] p);
    hit = (w & m) == p;
  endfunction

  logic same_ops;

  assign same_ops = ({instr[9], instr[3:0]} == instr[8:4]);
  assign bit_sel = instr[2:0];
  assign io_addr = instr[7:3];
  assign imm = {instr[11:8], instr[3:0]};
  assign koff = instr[9:3];

  always_comb begin
    op = BSU_OP_NONE;
    reg_addr = instr[8:4];
    want_set = 1'b0;
    if (hit(instr, MASK_CMPI, PAT_CMPI)) begin
      op = BSU_OP_CMPI;
      reg_addr = CMPI_REG_BASE | {1'b0, instr[7:4]};
    end else if (hit(instr, MASK_SKIP_REG, PAT_SKIP_REG)) begin
      op = BSU_OP_SKIP_REG;
      want_set = instr[9];
    end else if (hit(instr, MASK_SKIP_IO, PAT_SKIP_IO)) begin
      op = BSU_OP_SKIP_IO;
      want_set = instr[9];
    end else if (hit(instr, MASK_BRANCH, PAT_BRANCH)) begin
      op = BSU_OP_BRANCH;
      want_set = ~instr[10];
    end else if (hit(instr, MASK_IO_BIT, PAT_IO_BIT)) begin
      op = BSU_OP_IO_BIT;
      want_set = instr[9];
    end else if (hit(instr, MASK_ADD, PAT_SHL) && same_ops) begin
      op = BSU_OP_SHL;
    end else if (hit(instr, MASK_ADD, PAT_ROTL) && same_ops) begin
      op = BSU_OP_ROTL;
    end else if (hit(instr, MASK_ONE, PAT_SHR)) begin
      op = BSU_OP_SHR;
    end else if (hit(instr, MASK_ONE, PAT_ROTR)) begin
      op = BSU_OP_ROTR;
    end else if (hit(instr, MASK_ONE, PAT_SHRA)) begin
      op = BSU_OP_SHRA;
    end else if (hit(instr, MASK_ONE, PAT_SWAP)) begin
      op = BSU_OP_SWAP;
    end else if (hit(instr, MASK_BITT, PAT_TSAVE)) begin
      op = BSU_OP_TSAVE;
    end else if (hit(instr, MASK_BITT, PAT_TLOAD)) begin
      op = BSU_OP_TLOAD;
    end else if (instr == PAT_GIE) begin
      op = BSU_OP_GIE;
    end
  end

endmodule

// ---- verilog/bsu_alu.sv ----
// Purpose: compare-with-immediate, shifts, rotates and nibble swap
// Assumes: combinational; status register supplied by the caller
// Notes: flags not touched by an operation pass through unchanged
module bsu_alu (
  // operands
  input wire bsu_pkg::bsu_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] imm,
  input wire logic [7:0] flags_in,
  // results
  output logic [7:0] result,
  output logic [7:0] flags_out
);
  import bsu_pkg::*;

  logic [7:0] r;
  logic c;
  logic n;
  logic v;

  always_comb begin
    r = a;
    c = flags_in[FLAG_C];
    flags_out = flags_in;
    case (op)
      BSU_OP_CMPI: begin
        r = a - imm;
        c = (~a[7] & imm[7]) | (imm[7] & r[7]) | (r[7] & ~a[7]);
        flags_out[FLAG_H] = (~a[3] & imm[3]) | (imm[3] & r[3]) | (r[3] & ~a[3]);
      end
      BSU_OP_SHL: begin
        r = {a[6:0], 1'b0};
        c = a[7];
        flags_out[FLAG_H] = a[3];
      end
      BSU_OP_SHR: begin
        r = {1'b0, a[7:1]};
        c = a[0];
      end
      BSU_OP_ROTL: begin
        r = {a[6:0], flags_in[FLAG_C]};
        c = a[7];
        flags_out[FLAG_H] = a[3];
      end
      BSU_OP_ROTR: begin
        r = {flags_in[FLAG_C], a[7:1]};
        c = a[0];
      end
      BSU_OP_SHRA: begin
        r = {a[7], a[7:1]};
        c = a[0];
      end
      BSU_OP_SWAP: begin
        r = {a[3:0], a[7:4]};
      end
      default: begin
        r = a;
      end
    endcase
    n = r[7];
    if (op == BSU_OP_CMPI) begin
      v = (a[7] & ~imm[7] & ~r[7]) | (~a[7] & imm[7] & r[7]);
    end else begin
      v = n ^ c;
    end
    if (op != BSU_OP_SWAP && op != BSU_OP_NONE) begin
      flags_out[FLAG_C] = c;
      flags_out[FLAG_Z] = (r == 8'h00);
      flags_out[FLAG_N] = n;
      flags_out[FLAG_V] = v;
      flags_out[FLAG_S] = n ^ v;
    end
    result = r;
  end

endmodule

// ---- verilog/bsu_top.sv ----
// Purpose: executes compare-immediate, skips, branches, bit and shift instructions
// Assumes: the core supplies the addressed register and I/O values with ISSUE
// Notes: the unit owns the program counter and the status register
module bsu_top #(
  parameter int PC_W = 16
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // instruction issue
  input wire logic ISSUE,
  input wire logic [15:0] INSTR,
  input wire logic [7:0] RD_VAL,
  input wire logic [7:0] IO_VAL,
  input wire logic NEXT_TWO_WORD,
  output logic READY,
  output logic DONE,
  output logic UNKNOWN,
  // register file write
  output logic REG_WE,
  output logic [4:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  // i/o space write
  output logic IO_WE,
  output logic [4:0] IO_ADDR,
  output logic [7:0] IO_WDATA,
  // core state
  output logic [PC_W-1:0] PC,
  output logic [7:0] STATUS,
  // software port
  input wire logic [3:0] SW_ADDR,
  input wire logic [7:0] SW_WDATA,
  input wire logic SW_WR,
  input wire logic SW_RD,
  output logic [7:0] SW_RDATA
);
  import bsu_pkg::*;

  // ----------------------------------------------------------------
  // decode and datapath
  // ----------------------------------------------------------------
  bsu_op_t op;
  logic [4:0] dec_reg;
  logic [4:0] dec_io;
  logic [2:0] dec_bit;
  logic [7:0] dec_imm;
  logic [6:0] dec_k;
  logic dec_set;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;

  bsu_decode u_decode (
    .instr(INSTR),
    .op(op),
    .reg_addr(dec_reg),
    .io_addr(dec_io),
    .bit_sel(dec_bit),
    .imm(dec_imm),
    .koff(dec_k),
    .want_set(dec_set)
  );

  bsu_alu u_alu (
    .op(op),
    .a(RD_VAL),
    .imm(dec_imm),
    .flags_in(STATUS),
    .result(alu_res),
    .flags_out(alu_flags)
  );

  // ----------------------------------------------------------------
  // condition evaluation
  // ----------------------------------------------------------------
  logic take;
  logic start;
  logic is_shift;
  logic [1:0] next_extra;
  logic [PC_W-1:0] next_pc;
  logic [PC_W-1:0] k_ext;
  logic [7:0] io_mod;

  assign start = ISSUE && READY;
  assign k_ext = {{(PC_W-7){dec_k[6]}}, dec_k};
  assign is_shift = (op == BSU_OP_SHL) || (op == BSU_OP_SHR) || (op == BSU_OP_ROTL) ||
                    (op == BSU_OP_ROTR) || (op == BSU_OP_SHRA) || (op == BSU_OP_SWAP);

  always_comb begin
    io_mod = IO_VAL;
    io_mod[dec_bit] = dec_set;
  end

  always_comb begin
    case (op)
      BSU_OP_SKIP_REG: take = (RD_VAL[dec_bit] == dec_set);
      BSU_OP_SKIP_IO: take = (IO_VAL[dec_bit] == dec_set);
      // bit s of status picks C, Z, N, V, S, H, T or I
      BSU_OP_BRANCH: take = (STATUS[dec_bit] == dec_set);
      default: take = 1'b0;
    endcase
  end

  always_comb begin
    next_pc = PC + {{(PC_W-1){1'b0}}, 1'b1};
    next_extra = 2'h0;
    case (op)
      BSU_OP_SKIP_REG, BSU_OP_SKIP_IO: begin
        if (take) begin
          next_pc = PC + (NEXT_TWO_WORD ? PC_W'(3) : PC_W'(2));
          next_extra = NEXT_TWO_WORD ? EXTRA_SKIP2 : EXTRA_SKIP1;
        end
      end
      BSU_OP_BRANCH: begin
        if (take) begin
          next_pc = PC + k_ext + {{(PC_W-1){1'b0}}, 1'b1};
          next_extra = EXTRA_BRANCH;
        end
      end
      BSU_OP_IO_BIT: begin
        next_extra = EXTRA_IO_BIT;
      end
      default: begin
        next_extra = 2'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  bsu_state_t state;
  bsu_state_t next_state;
  logic [1:0] extra;
  logic [7:0] ctrl;
  logic io_pending;

  always_comb begin
    next_state = state;
    case (state)
      BSU_ST_IDLE: begin
        if (start && next_extra != 2'h0) begin
          next_state = BSU_ST_WAIT;
        end else if (!ctrl[CTRL_ENABLE]) begin
          next_state = BSU_ST_OFF;
        end
      end
      BSU_ST_WAIT: begin
        if (extra == 2'h1) begin
          next_state = ctrl[CTRL_ENABLE] ? BSU_ST_IDLE : BSU_ST_OFF;
        end
      end
      BSU_ST_OFF: begin
        if (ctrl[CTRL_ENABLE]) begin
          next_state = BSU_ST_IDLE;
        end
      end
      default: begin
        next_state = BSU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= BSU_ST_IDLE;
      extra <= 2'h0;
    end else begin
      state <= next_state;
      if (state == BSU_ST_IDLE && start) begin
        extra <= next_extra;
      end else if (extra != 2'h0) begin
        extra <= extra - 2'h1;
      end
    end
  end

  // ready mirrors the state to come so that it sits in a flip-flop
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      READY <= 1'b0;
    end else begin
      READY <= (next_state == BSU_ST_IDLE) && ctrl[CTRL_ENABLE];
    end
  end

  // done pulses in the cycle after the last clock edge of every instruction
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DONE <= 1'b0;
      UNKNOWN <= 1'b0;
    end else begin
      DONE <= (start && next_extra == 2'h0) || (state == BSU_ST_WAIT && extra == 2'h1);
      UNKNOWN <= start && (op == BSU_OP_NONE);
    end
  end

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PC <= '0;
    end else if (start) begin
      PC <= next_pc;
    end else if (SW_WR && SW_ADDR == OFS_PC_LO) begin
      PC <= {PC[PC_W-1:8], SW_WDATA};
    end else if (SW_WR && SW_ADDR == OFS_PC_HI) begin
      PC <= {SW_WDATA[PC_W-9:0], PC[7:0]};
    end
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      STATUS <= RST_STATUS;
    end else if (start) begin
      case (op)
        BSU_OP_CMPI: STATUS <= alu_flags;
        BSU_OP_SHL, BSU_OP_SHR: STATUS <= alu_flags;
        BSU_OP_ROTL, BSU_OP_ROTR: STATUS <= alu_flags;
        BSU_OP_SHRA: STATUS <= alu_flags;
        BSU_OP_TSAVE: STATUS[FLAG_T] <= RD_VAL[dec_bit];
        BSU_OP_GIE: STATUS[FLAG_I] <= 1'b1;
        default: STATUS <= STATUS;
      endcase
    end else if (SW_WR && SW_ADDR == OFS_STATUS) begin
      STATUS <= SW_WDATA;
    end
  end

  // ----------------------------------------------------------------
  // register file write-back
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_WE <= 1'b0;
      REG_ADDR <= 5'h00;
      REG_WDATA <= 8'h00;
    end else begin
      REG_WE <= start && (is_shift || op == BSU_OP_TLOAD);
      if (start && is_shift) begin
        REG_ADDR <= dec_reg;
        REG_WDATA <= alu_res;
      end else if (start && op == BSU_OP_TLOAD) begin
        REG_ADDR <= dec_reg;
        REG_WDATA <= RD_VAL;
        REG_WDATA[dec_bit] <= STATUS[FLAG_T];
      end
    end
  end

  // ----------------------------------------------------------------
  // i/o bit write, issued in the second clock
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      io_pending <= 1'b0;
      IO_WE <= 1'b0;
      IO_ADDR <= 5'h00;
      IO_WDATA <= 8'h00;
    end else begin
      io_pending <= start && (op == BSU_OP_IO_BIT);
      IO_WE <= io_pending;
      if (start && op == BSU_OP_IO_BIT) begin
        IO_ADDR <= dec_io;
        IO_WDATA <= io_mod;
      end
    end
  end

  // ----------------------------------------------------------------
  // software port: control, counter and read-back
  // ----------------------------------------------------------------
  logic [7:0] count;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl <= RST_CTRL;
    end else if (SW_WR && SW_ADDR == OFS_CTRL) begin
      ctrl <= {7'h00, SW_WDATA[CTRL_ENABLE]};
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      count <= 8'h00;
    end else if (SW_WR && SW_ADDR == OFS_COUNT) begin
      count <= 8'h00;
    end else if (start) begin
      count <= count + 8'h01;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SW_RDATA <= 8'h00;
    end else if (SW_RD) begin
      case (SW_ADDR)
        OFS_STATUS: SW_RDATA <= STATUS;
        OFS_PC_LO: SW_RDATA <= PC[7:0];
        OFS_PC_HI: SW_RDATA <= 8'(PC[PC_W-1:8]);
        OFS_CTRL: SW_RDATA <= ctrl;
        OFS_COUNT: SW_RDATA <= count;
        default: SW_RDATA <= 8'h00;
      endcase
    end else begin
      SW_RDATA <= 8'h00;
    end
  end

endmodule

// ---- dv/bsu_properties.sv ----
// Purpose: concurrent checks on the branch, skip and bit unit ports
// Assumes: instruction taken at an edge with ISSUE and READY high
// Notes: bound to bsu_top below
module bsu_properties
  import bsu_pkg::*;
#(
  parameter int PC_W = 16
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // instruction issue
  input wire logic ISSUE,
  input wire logic [15:0] INSTR,
  input wire logic [7:0] RD_VAL,
  input wire logic [7:0] IO_VAL,
  input wire logic NEXT_TWO_WORD,
  input wire logic READY,
  input wire logic DONE,
  // writes and state
  input wire logic REG_WE,
  input wire logic [7:0] REG_WDATA,
  input wire logic IO_WE,
  input wire logic [4:0] IO_ADDR,
  input wire logic [7:0] IO_WDATA,
  input wire logic [PC_W-1:0] PC,
  input wire logic [7:0] STATUS
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  logic go, br, tk, rskip, sio, iob, shl, tsave;
  logic [PC_W-1:0] tgt;
  logic [7:0] io_exp;
  assign go = ISSUE && READY;
  assign br = (INSTR & MASK_BRANCH) == PAT_BRANCH;
  assign tk = STATUS[INSTR[2:0]] != INSTR[10];
  assign rskip = (INSTR & MASK_SKIP_REG) == PAT_SKIP_REG && RD_VAL[INSTR[2:0]] == INSTR[9];
  assign sio = (INSTR & MASK_SKIP_IO) == PAT_SKIP_IO && IO_VAL[INSTR[2:0]] == INSTR[9];
  assign iob = (INSTR & MASK_IO_BIT) == PAT_IO_BIT;
  assign shl = (INSTR & MASK_ADD) == PAT_SHL && INSTR[9] == INSTR[8]
    && INSTR[3:0] == INSTR[7:4];
  assign tsave = (INSTR & MASK_BITT) == PAT_TSAVE;
  assign tgt = PC + PC_W'(1) + PC_W'($signed(INSTR[9:3]));
  assign io_exp = INSTR[9] ? (IO_VAL | (8'h01 << INSTR[2:0]))
    : (IO_VAL & ~(8'h01 << INSTR[2:0]));

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_br_taken;
    go && br && tk |=> !READY && PC == $past(tgt) ##1 DONE && READY;
  endproperty
  a_br_taken: assert property (p_br_taken) else $error("taken branch wrong");
  property p_br_not;
    go && br && !tk |=> DONE && PC == $past(PC) + PC_W'(1);
  endproperty
  a_br_not: assert property (p_br_not) else $error("untaken branch wrong");
  property p_br_flags;
    go && br |=> $stable(STATUS);
  endproperty
  a_br_flags: assert property (p_br_flags) else $error("branch moved flags");
  property p_skip_reg;
    go && rskip && !NEXT_TWO_WORD |=> !DONE ##1 DONE && PC == $past(PC, 2) + PC_W'(2);
  endproperty
  a_skip_reg: assert property (p_skip_reg) else $error("register skip wrong");
  property p_skip_io2;
    go && sio && NEXT_TWO_WORD |=> (!DONE)[*2] ##1 DONE && PC == $past(PC, 3) + PC_W'(3);
  endproperty
  a_skip_io2: assert property (p_skip_io2) else $error("io skip wrong");
  property p_io_bit;
    go && iob |=> !READY ##1 IO_WE && DONE && IO_WDATA == $past(io_exp, 2)
      && IO_ADDR == $past(INSTR[7:3], 2);
  endproperty
  a_io_bit: assert property (p_io_bit) else $error("io bit write wrong");
  property p_shl;
    go && shl |=> REG_WE && REG_WDATA == {$past(RD_VAL[6:0]), 1'b0}
      && STATUS[FLAG_C] == $past(RD_VAL[7]);
  endproperty
  a_shl: assert property (p_shl) else $error("shift left wrong");
  property p_tsave;
    go && tsave |=> STATUS[FLAG_T] == $past(RD_VAL[INSTR[2:0]]);
  endproperty
  a_tsave: assert property (p_tsave) else $error("bit store wrong");
  property p_gie;
    go && INSTR == PAT_GIE |=> STATUS[FLAG_I];
  endproperty
  a_gie: assert property (p_gie) else $error("global enable wrong");
endmodule

bind bsu_top bsu_properties #(.PC_W(PC_W)) bsu_properties_inst (.CLK(CLK), .RST(RST),
  .ISSUE(ISSUE), .INSTR(INSTR), .RD_VAL(RD_VAL), .IO_VAL(IO_VAL),
  .NEXT_TWO_WORD(NEXT_TWO_WORD), .READY(READY), .DONE(DONE), .REG_WE(REG_WE),
  .REG_WDATA(REG_WDATA), .IO_WE(IO_WE), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA),
  .PC(PC), .STATUS(STATUS));

// ---- dv/tb.sv ----
// Purpose: self-checking bench for the branch, skip and bit unit
// Assumes: one clock, software port used to preset flags
// Notes: expected counter and flags kept in pc_m and sr
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bsu_pkg::*;
  logic CLK, RST, ISSUE, NEXT_TWO_WORD, SW_WR, SW_RD;
  logic READY, DONE, UNKNOWN, REG_WE, IO_WE;
  logic [15:0] INSTR, PC, pc_m;
  logic [7:0] RD_VAL, IO_VAL, SW_WDATA, SW_RDATA, REG_WDATA, IO_WDATA, STATUS, sr, a, k;
  logic [4:0] REG_ADDR, IO_ADDR;
  logic [3:0] SW_ADDR;
  logic [15:0] r16, ins;
  int failures, total_checks, n_iss, cyc;
  logic [7:0] pat [3] = '{8'ha1, 8'h5a, 8'h14};
  logic [7:0] vals [4] = '{8'h00, 8'h81, 8'h7f, 8'h18};
  logic [15:0] opc [6] = '{16'h3000, 16'h0f22, 16'h9526, 16'h1f22, 16'h9527, 16'h9525};

  bsu_top #(.PC_W(16)) bsu_top_inst (.CLK(CLK), .RST(RST), .ISSUE(ISSUE), .INSTR(INSTR),
    .RD_VAL(RD_VAL), .IO_VAL(IO_VAL), .NEXT_TWO_WORD(NEXT_TWO_WORD), .READY(READY),
    .DONE(DONE), .UNKNOWN(UNKNOWN), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .IO_WE(IO_WE), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA),
    .PC(PC), .STATUS(STATUS), .SW_ADDR(SW_ADDR), .SW_WDATA(SW_WDATA), .SW_WR(SW_WR),
    .SW_RD(SW_RD), .SW_RDATA(SW_RDATA));

  // ----------------------------------------------------------------
  // reference model: op 0 compare, 1-2 logical shifts, 3-4 rotates, 5 arithmetic shift
  // ----------------------------------------------------------------
  function automatic logic [15:0] alu_m(int op, logic [7:0] x, logic [7:0] y, logic [7:0] s);
    logic [7:0] r;
    logic c;
    logic h;
    h = s[FLAG_H];
    case (op)
      0: begin
        r = x - y;
        c = (~x[7] & y[7]) | (y[7] & r[7]) | (r[7] & ~x[7]);
        h = (~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3]);
      end
      1: begin r = {x[6:0], 1'b0}; c = x[7]; h = x[3]; end
      2: begin r = {1'b0, x[7:1]}; c = x[0]; end
      3: begin r = {x[6:0], s[FLAG_C]}; c = x[7]; h = x[3]; end
      4: begin r = {s[FLAG_C], x[7:1]}; c = x[0]; end
      default: begin r = {x[7], x[7:1]}; c = x[0]; end
    endcase
    s[FLAG_C] = c;
    s[FLAG_H] = h;
    s[FLAG_N] = r[7];
    s[FLAG_Z] = (r == 8'h00);
    s[FLAG_V] = (op == 0) ? (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7]) : r[7] ^ c;
    s[FLAG_S] = s[FLAG_N] ^ s[FLAG_V];
    return {s, r};
  endfunction

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic sw_wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge CLK);
    SW_WR <= 1'b1;
    SW_ADDR <= ad;
    SW_WDATA <= d;
    @(posedge CLK);
    SW_WR <= 1'b0;
  endtask
  task automatic sw_rd(input logic [3:0] ad, input logic [7:0] e);
    @(posedge CLK);
    SW_RD <= 1'b1;
    SW_ADDR <= ad;
    @(posedge CLK);
    SW_RD <= 1'b0;
    @(negedge CLK);
    `CHK("sw_rdata", e, SW_RDATA)
  endtask
  task automatic run(input logic [15:0] w, input logic [7:0] rd, io, input logic two,
    input int ne, input logic [15:0] pe);
    int n;
    @(negedge CLK);
    while (READY !== 1'b1) @(negedge CLK);
    @(posedge CLK);
    ISSUE <= 1'b1;
    INSTR <= w;
    RD_VAL <= rd;
    IO_VAL <= io;
    NEXT_TWO_WORD <= two;
    @(posedge CLK);
    ISSUE <= 1'b0;
    n = 1;
    @(negedge CLK);
    while (DONE !== 1'b1 && n < 8) begin n++; @(negedge CLK); end
    n_iss++;
    `CHK("clocks", ne, n)
    `CHK("pc", pe, PC)
    `CHK("status", sr, STATUS)
    pc_m = pe;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin CLK = 1'b0; forever #50 CLK = ~CLK; end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin failures++; close_out(); end
  end

  initial begin
    {ISSUE, NEXT_TWO_WORD, SW_WR, SW_RD, INSTR, RD_VAL, IO_VAL, SW_WDATA, SW_ADDR} = '0;
    RST = 1'b1;
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    pc_m = 16'h0000;
    sw_rd(OFS_STATUS, RST_STATUS);
    sw_rd(OFS_CTRL, RST_CTRL);
    sw_rd(4'h7, 8'h00);
    $display("test reset done");
    foreach (pat[p]) begin
      sr = pat[p];
      sw_wr(OFS_STATUS, sr);
      for (int i = 0; i < 16; i++) begin
        k = 8'(i * 19 + p * 45);
        ins = {5'b11110, i[3], k[6:0], i[2:0]};
        r16 = (sr[i[2:0]] != i[3]) ? pc_m + 16'd1 + {{9{k[6]}}, k[6:0]} : pc_m + 16'd1;
        run(ins, 8'h00, 8'h00, 1'b0, (sr[i[2:0]] != i[3]) ? 2 : 1, r16);
      end
    end
    $display("test branches done");
    for (int i = 0; i < 8; i++) begin
      a = i[1] ? 8'h01 << 3'(i * 3) : ~(8'h01 << 3'(i * 3));
      ins = {6'b111111, i[0], 5'h12, 1'b0, 3'(i * 3)};
      r16 = (i[1] == i[0]) ? (i[2] ? 16'd3 : 16'd2) : 16'd1;
      run(ins, a, 8'h00, i[2], int'(r16), pc_m + r16);
      ins = {6'b100110, i[0], 1'b1, 5'h0b, 3'(i * 3)};
      run(ins, 8'h00, a, i[2], int'(r16), pc_m + r16);
    end
    $display("test skips done");
    for (int j = 0; j < 24; j++) begin
      a = vals[j % 4];
      k = vals[(j / 4 + 1) % 4];
      r16 = alu_m(j / 4, a, k, sr);
      sr = r16[15:8];
      ins = (j < 4) ? {4'h3, k[7:4], 4'h2, k[3:0]} : opc[j / 4];
      run(ins, a, 8'h00, 1'b0, 1, pc_m + 16'd1);
      if (j >= 4) `CHK("shift", r16[7:0], REG_WDATA)
      `CHK("reg_we", (j >= 4), REG_WE)
      if (j >= 4) `CHK("reg_addr", 5'h12, REG_ADDR)
    end
    run(16'h9522, 8'h3c, 8'h00, 1'b0, 1, pc_m + 16'd1);
    `CHK("swap", 8'hc3, REG_WDATA)
    `CHK("known", 1'b0, UNKNOWN)
    run(16'h0000, 8'h00, 8'h00, 1'b0, 1, pc_m + 16'd1);
    `CHK("unknown", 1'b1, UNKNOWN)
    sr[FLAG_T] = 1'b1;
    run(16'hfa05, 8'h20, 8'h00, 1'b0, 1, pc_m + 16'd1);
    run(16'hf920, 8'hf0, 8'h00, 1'b0, 1, pc_m + 16'd1);
    `CHK("bit_load", 8'hf1, REG_WDATA)
    sr = 8'h00;
    sw_wr(OFS_STATUS, sr);
    sr[FLAG_I] = 1'b1;
    run(PAT_GIE, 8'h00, 8'h00, 1'b0, 1, pc_m + 16'd1);
    run(16'h9a53, 8'h00, 8'h00, 1'b0, 2, pc_m + 16'd1);
    `CHK("io_set", 8'h08, IO_WDATA)
    `CHK("io_we", 1'b1, IO_WE)
    run(16'h9857, 8'h00, 8'hff, 1'b0, 2, pc_m + 16'd1);
    `CHK("io_clear", 8'h7f, IO_WDATA)
    `CHK("io_addr", 5'h0a, IO_ADDR)
    $display("test alu and bits done");
    sw_wr(OFS_CTRL, 8'h00);
    @(posedge CLK);
    ISSUE <= 1'b1;
    INSTR <= PAT_GIE;
    @(posedge CLK);
    ISSUE <= 1'b0;
    @(negedge CLK);
    `CHK("ready_off", 1'b0, READY)
    `CHK("pc_held", pc_m, PC)
    sw_wr(OFS_CTRL, 8'h01);
    sw_rd(OFS_COUNT, 8'(n_iss));
    $display("test refusal done");
    close_out();
  end
endmodule
